// >>> bench/seba_link_chk.sv
// Assertion checker for the two-wire link between both ends
module seba_link_chk #(
  parameter int T_WR_CYC = seba_pkg::T_WR_CYC_DFLT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link lines
  input wire logic scl,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic sda,
  // Device status
  input wire logic prog_busy
);
  logic        dpull;
  logic [31:0] busy_cnt_q;
  logic [3:0]  since_stop_q;

  // Device pulls the line low
  assign dpull = d_sda_oe & ~d_sda_o;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Length of the running programming cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) busy_cnt_q <= '0;
    else if (prog_busy) busy_cnt_q <= busy_cnt_q + 32'h1;
    else busy_cnt_q <= '0;
  end

  // Cycles since the last stop, saturating so old stops never match
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) since_stop_q <= 4'hf;
    else if (scl && $past(scl) && sda && !$past(sda)) since_stop_q <= 4'h0;
    else if (since_stop_q != 4'hf) since_stop_q <= since_stop_q + 4'h1;
  end

  //--------------------------------------------------------------------
  // Conditions and properties
  //--------------------------------------------------------------------
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence

  dev_edge_a: assert property ($changed(dpull) |-> !scl)
    else $error("device moved the data line while the clock was high");
  dev_slot_a: assert property ($rose(dpull) |-> !scl [*8] ##1 scl [*8])
    else $error("device drive did not span a whole clock slot");
  busy_quiet_a: assert property (prog_busy |-> !dpull)
    else $error("device drove the line while programming");
  busy_len_a: assert property ($fell(prog_busy) |-> busy_cnt_q == 32'(T_WR_CYC))
    else $error("programming cycle length wrong");
  busy_cause_a: assert property ($rose(prog_busy) |-> since_stop_q <= 4'ha)
    else $error("programming began without a recent stop");
  stop_free_a: assert property (stop_s |-> !dpull ##1 !dpull [*8])
    else $error("device still drives after a stop");
  start_free_a: assert property (start_s |-> !dpull)
    else $error("device drives the line at a start");
  line_owner_a: assert property (scl && $past(scl) && $changed(sda)
    |-> $changed(h_sda_oe & ~h_sda_o))
    else $error("line changed under a high clock without the controller");
endmodule // seba_link_chk

// >>> bench/serial_eeprom_bus_access_tb_top.sv
// Testbench joining the controller end and the EEPROM end
module serial_eeprom_bus_access_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         TWR  = 200;
  localparam logic [7:0] WSEL = 8'haa;  // Type code, pins 101, write
  localparam logic [7:0] RSEL = 8'hab;
  logic                core_clk = 1'b0;
  logic                resetn = 1'b1;  // Dropped later to make a real edge
  logic                cmd_valid = 1'b0;
  seba_pkg::seba_cmd_e cmd_kind = seba_pkg::CMD_START;
  logic [7:0]          cmd_wdata = 8'h00;
  logic                cmd_ack = 1'b0;
  logic [2:0]          pins = 3'h5;
  logic                cmd_ready, rsp_valid, rsp_nack, prog_busy, r_nack;
  logic [7:0]          rsp_rdata, r_data;
  int                  n_errors = 0;
  int                  n_compared = 0;

  always #5 core_clk = ~core_clk;

  seba_link_if link();
  seba_host u_seba_host (.core_clk(core_clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_nack(rsp_nack), .link(link));
  // Smallest density so all three select pins are compared
  seba_dev #(.DENS(0), .T_WR_CYC(TWR)) u_seba_dev (.core_clk(core_clk), .resetn(resetn),
    .select_input_high(pins[2]), .select_input_mid(pins[1]), .select_input_low(pins[0]),
    .prog_busy(prog_busy), .link(link));
  seba_link_chk #(.T_WR_CYC(TWR)) u_seba_link_chk (.core_clk(core_clk), .resetn(resetn),
    .scl(link.scl), .h_sda_o(link.h_sda_o), .h_sda_oe(link.h_sda_oe),
    .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe), .sda(link.sda),
    .prog_busy(prog_busy));

  //--------------------------------------------------------------------
  // Compare and command tasks
  //--------------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t bit %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t byte %h, expected %h", $time, got, exp);
    end
  endtask
  // One command, held for one clock, then bounded wait for the response
  task automatic xfer(input seba_pkg::seba_cmd_e k, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    cmd_kind = k;
    cmd_wdata = d;
    cmd_ack = a;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    chk_bit(cmd_ready, 1'b0);
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (!rsp_valid && n < 300);
    if (n >= 300) chk_bit(1'b0, 1'b1);
    r_data = rsp_rdata;
    r_nack = rsp_nack;
    chk_bit(cmd_ready, 1'b1);
  endtask
  task automatic st; xfer(seba_pkg::CMD_START, 8'h00, 1'b0); endtask
  task automatic sp; xfer(seba_pkg::CMD_STOP, 8'h00, 1'b0); endtask
  task automatic wb(input logic [7:0] d, input logic nk);
    xfer(seba_pkg::CMD_WRITE, d, 1'b0);
    chk_bit(r_nack, nk);
  endtask
  task automatic rb(input logic a, input logic [7:0] e);
    xfer(seba_pkg::CMD_READ, 8'h00, a);
    chk_byte(r_data, e);
    chk_bit(r_nack, ~a);
  endtask
  // Poll with a write select until the device answers again
  task automatic poll;
    int tries;
    tries = 0;
    do begin
      st();
      xfer(seba_pkg::CMD_WRITE, WSEL, 1'b0);
      tries++;
      if (r_nack) sp();
    end while (r_nack && tries < 40);
    chk_bit(tries > 1, 1'b1);
    chk_bit(r_nack, 1'b0);
    sp();
  endtask

  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  task automatic t_byte;
    st();
    wb(WSEL, 1'b0);
    wb(8'hff, 1'b0);
    wb(8'h3c, 1'b0);
    sp();
    chk_bit(link.scl & link.sda, 1'b1);
    repeat (10) @(posedge core_clk);
    #1 chk_bit(prog_busy, 1'b1);
    poll();
    $display("byte write done");
  endtask
  // Ten bytes from index 6 of an 8-byte page: wraps and overwrites
  task automatic t_page;
    st();
    wb(WSEL, 1'b0);
    wb(8'h06, 1'b0);
    for (int i = 0; i < 10; i++) wb(8'hd0 + 8'(i), 1'b0);
    sp();
    poll();
    st();
    wb(RSEL, 1'b0);
    for (int i = 0; i < 7; i++) rb(1'b1, 8'hd2 + 8'(i));
    rb(1'b0, 8'hd9);
    sp();
    st();
    wb(WSEL, 1'b0);
    wb(8'hff, 1'b0);
    st();
    wb(RSEL, 1'b0);
    rb(1'b1, 8'h3c);
    rb(1'b0, 8'hd2);
    sp();
    st();
    wb(RSEL, 1'b0);
    rb(1'b0, 8'hd3);
    sp();
    $display("page write and reads done");
  endtask
  task automatic t_addr;
    st();
    wb(WSEL, 1'b0);
    wb(8'h04, 1'b0);
    sp();
    repeat (10) @(posedge core_clk);
    #1 chk_bit(prog_busy, 1'b0);
    st();
    wb(RSEL, 1'b0);
    rb(1'b0, 8'hd6);
    sp();
    $display("address only done");
  endtask
  task automatic t_sel;
    st();
    wb(8'ha2, 1'b1);
    sp();
    st();
    wb(8'h2b, 1'b1);
    sp();
    pins = 3'h2;
    st();
    wb(8'ha5, 1'b0);
    rb(1'b0, 8'hd7);
    sp();
    pins = 3'h5;
    $display("select decode done");
  endtask

  task automatic summarize;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog: the whole run needs well under a millisecond
  initial begin
    #1000000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  // Asynchronous resets only fire on a falling edge, so make one
  initial begin
    #2 resetn = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    t_byte();
    t_page();
    t_addr();
    t_sel();
    summarize();
  end
endmodule // serial_eeprom_bus_access_tb_top

// >>> shared/seba_link_if.sv
// Two-wire link between the bus controller and the EEPROM end
interface seba_link_if;
  logic scl;       // Serial clock, made by the controller
  logic h_sda_o;   // Controller data level
  logic h_sda_oe;  // Controller pulls the line
  logic d_sda_o;   // Device data level
  logic d_sda_oe;  // Device pulls the line
  logic sda;       // Resolved line level

  // Open-drain wired-and with an implied pull-up
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

  modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
  modport dev  (input scl, output d_sda_o, output d_sda_oe, input sda);
endinterface

// >>> shared/seba_pkg.sv
// Shared constants and types for the serial EEPROM bus access block
//----------------------------------------------------------------------
// Function
// - Write select, then word address; device acknowledges
// - Stop after data byte starts programming
// - Programming busy: ignore bus, never acknowledge
// - Page is 8 or 16 bytes by density
// - Controller sends up to 7/15 more bytes
// - Every written data byte gets acknowledged
// - Write increments only low in-page address bits
// - Page overflow wraps, later bytes replace earlier
// - Select acknowledged only after programming completes
// - Select bit one means read
// - Counter holds last address plus one
// - Reads wrap whole memory, writes wrap page
// - Current read sends counter byte, then nack, stop
// - Random read: dummy write, restart, read select
// - Controller ack advances address, next byte out
// - Nack plus stop ends read, device releases
// - Compare used select pins, rest address bits
// - Last select bit picks read or write
// - Mismatch or stop returns to standby
//----------------------------------------------------------------------
package seba_pkg;

  //--------------------------------------------------------------------
  // Memory shape
  //--------------------------------------------------------------------
  localparam logic [3:0]  DEV_TYPE_CODE = 4'ha;
  localparam int          WADDR_W       = 8;
  localparam int          MEM_AW        = 11;
  localparam int          MEM_BYTES     = 2048;
  localparam int          PAGE_MAX      = 16;
  localparam int          PAGE_AW_SMALL = 3;
  localparam int          PAGE_AW_LARGE = 4;
  localparam int          DENS_DFLT     = 3;

  //--------------------------------------------------------------------
  // Bit slots inside one byte frame
  //--------------------------------------------------------------------
  localparam logic [3:0]  BIT_FIRST     = 4'h1;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam logic [1:0]  PH_LAST       = 2'h3;

  //--------------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------------
  localparam int          CORE_PERIOD_NS = 10;
  localparam int          T_WR_MS        = 5;
  localparam int          T_WR_CYC_DFLT  = T_WR_MS * 1000000 / CORE_PERIOD_NS;
  localparam int          SCL_PERIOD_NS  = 160;
  localparam int          QTR_CYC        = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);

  // Controller command kinds
  typedef enum logic [1:0] {
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ
  } seba_cmd_e;

endpackage

// >>> verilog/seba_cond.sv
// Start and stop condition detector for the EEPROM end
module seba_cond (
  // Reset
  input  wire logic resetn,
  // Bus lines
  input  wire logic scl,
  input  wire logic sda,
  // Condition toggles
  output logic      start_tgl,
  output logic      stop_tgl
);

  // Falling data while clock high marks a start
  always_ff @(negedge sda or negedge resetn) begin
    if (!resetn) begin
      start_tgl <= 1'b0;
    end else if (scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  // Rising data while clock high marks a stop
  always_ff @(posedge sda or negedge resetn) begin
    if (!resetn) begin
      stop_tgl <= 1'b0;
    end else if (scl) begin
      stop_tgl <= ~stop_tgl;
    end
  end

endmodule // seba_cond

// >>> verilog/seba_dev.sv
// EEPROM end: select decode, address counter, page buffer, programming
module seba_dev #(
  parameter int DENS     = seba_pkg::DENS_DFLT,
  parameter int T_WR_CYC = seba_pkg::T_WR_CYC_DFLT
) (
  // Core clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Hard-wired select inputs
  input  wire logic select_input_high,
  input  wire logic select_input_mid,
  input  wire logic select_input_low,
  // Status
  output logic      prog_busy,
  // Link
  seba_link_if.dev  link
);

  //--------------------------------------------------------------------
  // Variant shape
  //--------------------------------------------------------------------
  localparam int PG_AW = (DENS == 0) ? seba_pkg::PAGE_AW_SMALL
                                     : seba_pkg::PAGE_AW_LARGE;
  localparam int AW    = seba_pkg::WADDR_W + DENS;
  localparam int TW    = $clog2(T_WR_CYC + 1);
  localparam logic [10:0] AMASK  = 11'((1 << AW) - 1);
  localparam logic [10:0] PMASK  = 11'((1 << PG_AW) - 1);
  localparam logic [2:0]  HIMASK = 3'((1 << DENS) - 1);
  localparam logic [TW-1:0] T_LAST = TW'(T_WR_CYC - 1);

  typedef enum logic [2:0] {
    S_IDLE,
    S_DEVSEL,
    S_WADDR,
    S_WDATA,
    S_RDATA
  } seba_dst_e;

  // Type code plus the pins this density really uses
  function automatic logic sel_match(input logic [7:0] b,
                                     input logic [2:0] pins);
    logic type_ok;
    type_ok   = (b[7:4] == seba_pkg::DEV_TYPE_CODE);
    sel_match = type_ok && (((b[3:1] ^ pins) & ~HIMASK) == 3'h0);
  endfunction

  //--------------------------------------------------------------------
  // Storage
  //--------------------------------------------------------------------
  logic [7:0]  mem   [seba_pkg::MEM_BYTES];
  logic [7:0]  buf_q [seba_pkg::PAGE_MAX];
  logic [seba_pkg::PAGE_MAX-1:0] mask_q;

  //--------------------------------------------------------------------
  // Link domain state
  //--------------------------------------------------------------------
  seba_dst_e   state_q;
  logic [3:0]  bcnt_q;
  logic [6:0]  sh_q;
  logic        ack_q;
  logic        rd_q;
  logic [2:0]  hi_q;
  logic [7:0]  tx_q;
  logic [10:0] addr_q;
  logic [10:0] row_q;
  logic        got_data_q;
  logic        wr_tgl_q;
  logic        start_seen_q;
  logic        stop_seen_q;
  logic        busy_s1_q;
  logic        busy_s2_q;
  logic        sda_o_q;
  logic        sda_oe_q;
  logic [2:0]  pins_s1_q;
  logic [2:0]  pins_s2_q;

  // Core domain state
  logic        busy_q;
  logic        done_tgl_q;
  logic [TW-1:0] tmr_q;
  logic        stop_s1_q;
  logic        stop_s2_q;
  logic        stop_s3_q;
  logic        wr_s1_q;
  logic        wr_s2_q;

  logic        start_tgl;
  logic        stop_tgl;
  logic [7:0]  byte_in;
  logic [2:0]  pins;
  logic [3:0]  pg_idx;
  logic        frame_new;
  logic        frame_end;
  logic        byte_done;
  logic [10:0] rd_next;
  logic [10:0] wr_next;
  logic        stop_evt;
  logic        prog_end;

  seba_cond u_cond (
    .resetn    (resetn),
    .scl       (link.scl),
    .sda       (link.sda),
    .start_tgl (start_tgl),
    .stop_tgl  (stop_tgl)
  );

  // Condition toggles change while the clock is high, three quarters of a period
  // before the next rising edge reads them, so no extra flops here
  assign pins      = pins_s2_q;
  assign byte_in   = {sh_q, link.sda};
  assign frame_new = start_tgl ^ start_seen_q;
  assign frame_end = stop_tgl ^ stop_seen_q;
  assign byte_done = !frame_new && !frame_end && (state_q != S_IDLE)
                     && (bcnt_q == seba_pkg::BIT_LAST);
  assign pg_idx    = addr_q[3:0] & PMASK[3:0];
  assign rd_next   = (addr_q + 11'h001) & AMASK;
  assign wr_next   = (addr_q & ~PMASK) | ((addr_q + 11'h001) & PMASK);

  //--------------------------------------------------------------------
  // Protocol sequencer, sampled on rising clock
  //--------------------------------------------------------------------
  always_ff @(posedge link.scl or negedge resetn) begin
    if (!resetn) begin
      state_q      <= S_IDLE;
      bcnt_q       <= 4'h0;
      sh_q         <= 7'h00;
      ack_q        <= 1'b0;
      rd_q         <= 1'b0;
      hi_q         <= 3'h0;
      tx_q         <= 8'hff;
      addr_q       <= 11'h000;
      row_q        <= 11'h000;
      got_data_q   <= 1'b0;
      wr_tgl_q     <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
    end else begin
      start_seen_q <= start_tgl;
      stop_seen_q  <= stop_tgl;
      if (frame_new) begin
        state_q <= S_DEVSEL;
        bcnt_q  <= seba_pkg::BIT_FIRST;
        sh_q    <= {6'h00, link.sda};
        ack_q   <= 1'b0;
      end else if (frame_end || state_q == S_IDLE) begin
        state_q <= S_IDLE;
        bcnt_q  <= 4'h0;
        ack_q   <= 1'b0;
      end else if (bcnt_q < seba_pkg::ACK_SLOT) begin
        bcnt_q <= bcnt_q + 4'h1;
        sh_q   <= byte_in[6:0];
        if (byte_done) begin
          case (state_q)
            S_DEVSEL: begin
              // Busy device stays silent, which is what polling sees
              if (sel_match(byte_in, pins) && !busy_s2_q) begin
                ack_q <= 1'b1;
                rd_q  <= byte_in[0];
                hi_q  <= byte_in[3:1] & HIMASK;
              end else begin
                state_q <= S_IDLE;
              end
            end
            S_WADDR: begin
              ack_q      <= 1'b1;
              addr_q     <= {hi_q, byte_in} & AMASK;
              row_q      <= {hi_q, byte_in} & AMASK;
              got_data_q <= 1'b0;
            end
            S_WDATA: begin
              ack_q  <= 1'b1;
              addr_q <= wr_next;
              if (!got_data_q) begin
                got_data_q <= 1'b1;
                wr_tgl_q   <= ~wr_tgl_q;
              end
            end
            default: ack_q <= 1'b0;
          endcase
        end
      end else begin
        // Acknowledge slot
        bcnt_q <= 4'h0;
        ack_q  <= 1'b0;
        case (state_q)
          S_DEVSEL: begin
            if (rd_q) begin
              state_q <= S_RDATA;
              tx_q    <= mem[addr_q];
              addr_q  <= rd_next;
            end else begin
              state_q <= S_WADDR;
            end
          end
          S_WADDR: state_q <= S_WDATA;
          S_RDATA: begin
            if (!link.sda) begin
              tx_q   <= mem[addr_q];
              addr_q <= rd_next;
            end else begin
              state_q <= S_IDLE;
            end
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // Page buffer: in-page index wraps, so later bytes overwrite
  always_ff @(posedge link.scl) begin
    if (byte_done && state_q == S_WDATA) begin
      buf_q[pg_idx] <= byte_in;
    end
  end

  // Which buffer slots hold fresh bytes
  always_ff @(posedge link.scl or negedge resetn) begin
    if (!resetn) begin
      mask_q <= '0;
    end else if (byte_done && state_q == S_WADDR) begin
      mask_q <= '0;
    end else if (byte_done && state_q == S_WDATA) begin
      mask_q[pg_idx] <= 1'b1;
    end
  end

  // Select pins are board levels, so two flops before the compare
  always_ff @(posedge link.scl or negedge resetn) begin
    if (!resetn) begin
      pins_s1_q <= 3'h0;
      pins_s2_q <= 3'h0;
    end else begin
      pins_s1_q <= {select_input_high, select_input_mid, select_input_low};
      pins_s2_q <= pins_s1_q;
    end
  end

  // Programming flag brought into the link domain
  always_ff @(posedge link.scl or negedge resetn) begin
    if (!resetn) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= busy_q;
      busy_s2_q <= busy_s1_q;
    end
  end

  //--------------------------------------------------------------------
  // Line driver, updated on falling clock
  //--------------------------------------------------------------------
  always_ff @(negedge link.scl or negedge resetn) begin
    if (!resetn) begin
      sda_o_q  <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (state_q == S_RDATA && bcnt_q < seba_pkg::ACK_SLOT) begin
      sda_o_q  <= tx_q[3'(seba_pkg::BIT_LAST - bcnt_q)];
      sda_oe_q <= ~tx_q[3'(seba_pkg::BIT_LAST - bcnt_q)];
    end else if (ack_q && bcnt_q == seba_pkg::ACK_SLOT) begin
      sda_o_q  <= 1'b0;
      sda_oe_q <= 1'b1;
    end else begin
      sda_o_q  <= 1'b1;
      sda_oe_q <= 1'b0;
    end
  end

  assign link.d_sda_o  = sda_o_q;
  assign link.d_sda_oe = sda_oe_q;

  //--------------------------------------------------------------------
  // Core domain: stop detection and the timed programming cycle
  //--------------------------------------------------------------------
  assign stop_evt = stop_s2_q ^ stop_s3_q;
  assign prog_end = busy_q && (tmr_q == T_LAST);

  // Stop toggle and write toggle crossings
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
      stop_s3_q <= 1'b0;
      wr_s1_q   <= 1'b0;
      wr_s2_q   <= 1'b0;
    end else begin
      stop_s1_q <= stop_tgl;
      stop_s2_q <= stop_s1_q;
      stop_s3_q <= stop_s2_q;
      wr_s1_q   <= wr_tgl_q;
      wr_s2_q   <= wr_s1_q;
    end
  end

  // Only a frame that carried data starts a cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q     <= 1'b0;
      done_tgl_q <= 1'b0;
      tmr_q      <= '0;
    end else if (stop_evt && !busy_q && (wr_s2_q != done_tgl_q)) begin
      busy_q     <= 1'b1;
      done_tgl_q <= wr_s2_q;
      tmr_q      <= '0;
    end else if (prog_end) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      tmr_q <= tmr_q + TW'(1);
    end
  end

  // Buffer is quiet after the stop, so the core may read it freely
  always_ff @(posedge core_clk) begin
    if (prog_end) begin
      for (int i = 0; i < seba_pkg::PAGE_MAX; i++) begin
        if (mask_q[i]) begin
          mem[(row_q & ~PMASK) | 11'(i)] <= buf_q[i];
        end
      end
    end
  end

  assign prog_busy = busy_q;

endmodule // seba_dev

// >>> verilog/seba_host.sv
// Bus controller end: byte-level command engine and clock divider
module seba_host (
  // Core clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // Command
  input  wire logic                cmd_valid,
  input  wire seba_pkg::seba_cmd_e cmd_kind,
  input  wire logic [7:0]          cmd_wdata,
  input  wire logic                cmd_ack,
  output logic                     cmd_ready,
  // Response
  output logic                     rsp_valid,
  output logic [7:0]               rsp_rdata,
  output logic                     rsp_nack,
  // Link
  seba_link_if.host                link
);

  localparam int QW = $clog2(seba_pkg::QTR_CYC + 1);
  localparam logic [QW-1:0] Q_LAST = QW'(seba_pkg::QTR_CYC - 1);

  typedef enum logic {H_IDLE, H_RUN} seba_hst_e;

  // Clock and data levels for one quarter of a symbol
  function automatic logic [1:0] sym_lvl(input seba_pkg::seba_cmd_e k,
                                         input logic [1:0] ph,
                                         input logic b,
                                         input logic held);
    sym_lvl = {1'b0, held};
    case (k)
      seba_pkg::CMD_START: begin
        if (ph == 2'h1) sym_lvl = 2'b01;
        if (ph == 2'h2) sym_lvl = 2'b11;
        if (ph == 2'h3) sym_lvl = 2'b10;
      end
      seba_pkg::CMD_STOP: begin
        if (ph == 2'h1) sym_lvl = 2'b00;
        if (ph == 2'h2) sym_lvl = 2'b10;
        if (ph == 2'h3) sym_lvl = 2'b11;
      end
      default: begin
        if (ph != 2'h0) sym_lvl = {ph[1], b};
      end
    endcase
  endfunction

  seba_hst_e           st_q;
  seba_pkg::seba_cmd_e kind_q;
  logic [QW-1:0]       qcnt_q;
  logic [1:0]          ph_q;
  logic [3:0]          bit_q;
  logic [8:0]          tx_q;
  logic [8:0]          rx_q;
  logic                scl_q;
  logic                sda_q;
  logic                sda_s1_q;
  logic                sda_s2_q;
  logic                ready_q;
  logic                rsp_q;
  logic [7:0]          rdata_q;
  logic                nack_q;
  logic [8:0]          rx_n;
  logic [8:0]          tx_new;
  logic                last_sym;

  // Write shifts out data then frees the ack slot; read answers ack
  assign tx_new   = (cmd_kind == seba_pkg::CMD_READ) ? {8'hff, ~cmd_ack}
                                                     : {cmd_wdata, 1'b1};
  assign rx_n     = {rx_q[7:0], sda_s2_q};
  assign last_sym = (kind_q == seba_pkg::CMD_START) ||
                    (kind_q == seba_pkg::CMD_STOP) ||
                    (bit_q == seba_pkg::ACK_SLOT);

  // Line level from the far side is a pin, so two flops first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // Symbol engine; the user sequences starts, bytes and stops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= H_IDLE;
      kind_q  <= seba_pkg::CMD_STOP;
      qcnt_q  <= '0;
      ph_q    <= 2'h0;
      bit_q   <= 4'h0;
      tx_q    <= 9'h1ff;
      rx_q    <= 9'h000;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      ready_q <= 1'b1;
      rsp_q   <= 1'b0;
      rdata_q <= 8'h00;
      nack_q  <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (cmd_valid) begin
            st_q           <= H_RUN;
            kind_q         <= cmd_kind;
            tx_q           <= tx_new;
            qcnt_q         <= '0;
            ph_q           <= 2'h0;
            bit_q          <= 4'h0;
            ready_q        <= 1'b0;
            {scl_q, sda_q} <= sym_lvl(cmd_kind, 2'h0, tx_new[8], sda_q);
          end
        end
        H_RUN: begin
          if (qcnt_q != Q_LAST) begin
            qcnt_q <= qcnt_q + QW'(1);
          end else begin
            qcnt_q <= '0;
            if (ph_q != seba_pkg::PH_LAST) begin
              ph_q           <= ph_q + 2'h1;
              {scl_q, sda_q} <= sym_lvl(kind_q, ph_q + 2'h1, tx_q[8], sda_q);
            end else begin
              rx_q <= rx_n;
              if (last_sym) begin
                st_q    <= H_IDLE;
                ready_q <= 1'b1;
                rsp_q   <= 1'b1;
                rdata_q <= rx_n[8:1];
                nack_q  <= rx_n[0];
              end else begin
                ph_q           <= 2'h0;
                bit_q          <= bit_q + 4'h1;
                tx_q           <= {tx_q[7:0], 1'b1};
                {scl_q, sda_q} <= sym_lvl(kind_q, 2'h0, tx_q[7], sda_q);
              end
            end
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Open drain: enable only while pulling low
  assign link.scl      = scl_q;
  assign link.h_sda_o  = sda_q;
  assign link.h_sda_oe = ~sda_q;
  assign cmd_ready     = ready_q;
  assign rsp_valid     = rsp_q;
  assign rsp_rdata     = rdata_q;
  assign rsp_nack      = nack_q;

endmodule // seba_host
